//--- otp_overlay_region_control_tb.sv
`timescale 1ns/100ps
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin err_total++; $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module otp_overlay_region_control_tb;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	wire  [3:0]  avs_address;
	wire         avs_read;
	wire         avs_write;
	wire  [31:0] avs_writedata;
	wire  [3:0]  avs_byteenable;
	wire  [31:0] avs_readdata;
	wire         avs_waitrequest;
	wire         ovl;
	int          err_total = 0;
	int          n_checks  = 0;
	int          seed;
	logic [31:0] exp_q[$];
	logic [31:0] msk_q[$];
	logic [31:0] e;
	logic [31:0] m;
	logic [31:0] d0;
	logic [31:0] d1;
	logic [31:0] d2;
	logic [31:0] r;
	otpov_pkg::otpov_cmd_type ign[5] = '{otpov_pkg::OTPOV_BYPASS, otpov_pkg::OTPOV_CFI, otpov_pkg::OTPOV_ACCEL,
		otpov_pkg::OTPOV_SUSPEND, otpov_pkg::OTPOV_RESUME};

	always #4 clk = ~clk;

	otpov_top uut (.CORE_CLK(clk), .RST(rst), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
		.AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(avs_byteenable),
		.AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest), .OVERLAY_ACTIVE(ovl));

	otpov_host host (.CORE_CLK(clk), .AVS_WAITREQUEST(avs_waitrequest), .AVS_ADDRESS(avs_address),
		.AVS_READ(avs_read), .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(avs_byteenable));

	// ==========================================================================
	// Read monitor: each accepted read retires the oldest expectation.
	always @(posedge clk) begin
		if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && exp_q.size() > 0) begin
			e = exp_q.pop_front();
			m = msk_q.pop_front();
			`CHK(avs_readdata & m, e & m)
		end
	end

	task automatic rd(input logic [3:0] a, input logic [31:0] ex, input logic [31:0] mk);
		exp_q.push_back(ex);
		msk_q.push_back(mk);
		host.xfer(a, 32'h00000000, 1'b1);
	endtask : rd

	task automatic cmd(input otpov_pkg::otpov_cmd_type c, input logic [19:0] a, input logic [31:0] d);
		host.xfer(otpov_pkg::REG_ADDR, {12'h000, a}, 1'b0);
		host.xfer(otpov_pkg::REG_WDATA, d, 1'b0);
		host.xfer(otpov_pkg::REG_CMD, {28'h0000000, c}, 1'b0);
	endtask : cmd

	task automatic fread(input logic [19:0] a, input logic [31:0] ex);
		cmd(otpov_pkg::OTPOV_READ, a, 32'h00000000);
		rd(otpov_pkg::REG_RDATA, ex, 32'hFFFFFFFF);
	endtask : fread

	task automatic stat(input int b, input logic v);
		rd(otpov_pkg::REG_STATUS, {31'h00000000, v} << b, 32'h00000001 << b);
	endtask : stat

	// The flag is registered, so a few edges are allowed for it to settle.
	task automatic ov(input logic v);
		repeat (3) @(negedge clk);
		`CHK(ovl, v)
	endtask : ov

	task automatic end_sim;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : end_sim

	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		end_sim();
	end

	// ==========================================================================
	// Main sequence.
	initial begin
		seed = 39;
		d0 = $random(seed);
		d1 = $random(seed);
		d2 = $random(seed);
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		ov(1'b0);
		rd(otpov_pkg::REG_CONFIG, otpov_pkg::CONFIG_RESET, 32'hFFFFFFFF);
		host.xfer(4'hF, d0, 1'b0);
		rd(4'hF, 32'h00000000, 32'hFFFFFFFF);
		cmd(otpov_pkg::OTPOV_PROG, 20'h00005, d0);
		cmd(otpov_pkg::OTPOV_PROG, 20'h40000, d1);
		cmd(otpov_pkg::OTPOV_PROG, 20'h80000, d1);
		cmd(otpov_pkg::OTPOV_GUARD_PROG, 20'h00000, 32'h00000001);
		cmd(otpov_pkg::OTPOV_GUARD_VERIFY, 20'h00000, 32'h00000000);
		rd(otpov_pkg::REG_RDATA, otpov_pkg::INVALID_DATA, 32'hFFFFFFFF);
		host.seq(otpov_pkg::OTPOV_ENTRY, 2);
		ov(1'b0);
		host.seq(otpov_pkg::OTPOV_ENTRY, 1);
		ov(1'b1);
		cmd(otpov_pkg::OTPOV_GUARD_VERIFY, 20'h00000, 32'h00000000);
		rd(otpov_pkg::REG_RDATA, 32'h00000000, 32'h00000001);
		cmd(otpov_pkg::OTPOV_PROG, 20'h00005, d2);
		fread(20'h00005, d2);
		cmd(otpov_pkg::OTPOV_PROG, 20'h00006, 32'h00000000);
		fread(20'h00006, otpov_pkg::ERASED_WORD);
		for (int i = 0; i < 3; i++) begin
			r = $random(seed);
			fread(20'h00040 + {9'h000, r[10:0] % 11'h7C0}, otpov_pkg::INVALID_DATA);
			fread(20'h00800 + {1'h0, r[30:12]}, otpov_pkg::INVALID_DATA);
		end
		foreach (ign[i]) begin
			cmd(ign[i], 20'h40000, 32'h00000000);
			stat(otpov_pkg::ST_IGNORED, 1'b1);
			stat(otpov_pkg::ST_SUSP, 1'b0);
		end
		cmd(otpov_pkg::OTPOV_LOCK_OTP, 20'h00000, 32'h00000000);
		stat(otpov_pkg::ST_OTP_LOCK, 1'b1);
		cmd(otpov_pkg::OTPOV_PROG, 20'h00005, 32'h00000000);
		fread(20'h00005, d2);
		cmd(otpov_pkg::OTPOV_SECT_ERASE, 20'h00000, 32'h00000000);
		cmd(otpov_pkg::OTPOV_SECT_ERASE, 20'h80000, 32'h00000000);
		fread(20'h00005, d2);
		cmd(otpov_pkg::OTPOV_CHIP_ERASE, 20'h00000, 32'h00000000);
		fread(20'h00005, d2);
		cmd(otpov_pkg::OTPOV_PGUARD_OP, 20'h00000, 32'h00000000);
		stat(otpov_pkg::ST_BUSY, 1'b1);
		repeat (12) @(posedge clk);
		stat(otpov_pkg::ST_BUSY, 1'b0);
		for (int i = 0; i < 2; i++) begin
			host.xfer(otpov_pkg::REG_CONFIG, (i == 0) ? 32'h00000001 : 32'h00000003, 1'b0);
			fread((i == 0) ? 20'hFFFC5 : 20'h7FFC5, d2);
			fread(20'h0FF00, otpov_pkg::INVALID_DATA);
			fread(20'h00005, otpov_pkg::INVALID_DATA);
		end
		host.xfer(otpov_pkg::REG_CONFIG, 32'h00000000, 1'b0);
		host.seq(otpov_pkg::OTPOV_EXIT, 3);
		ov(1'b1);
		host.seq(otpov_pkg::OTPOV_EXIT, 1);
		ov(1'b0);
		fread(20'h00005, d0);
		fread(20'h40000, otpov_pkg::ERASED_WORD);
		fread(20'h80000, otpov_pkg::ERASED_WORD);
		cmd(otpov_pkg::OTPOV_SUSPEND, 20'h00000, 32'h00000000);
		stat(otpov_pkg::ST_SUSP, 1'b1);
		host.seq(otpov_pkg::OTPOV_ENTRY, 3);
		ov(1'b1);
		cmd(otpov_pkg::OTPOV_RESUME, 20'h00000, 32'h00000000);
		stat(otpov_pkg::ST_SUSP, 1'b1);
		host.seq(otpov_pkg::OTPOV_EXIT, 4);
		cmd(otpov_pkg::OTPOV_RESUME, 20'h00000, 32'h00000000);
		stat(otpov_pkg::ST_SUSP, 1'b0);
		host.seq(otpov_pkg::OTPOV_ENTRY, 3);
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		ov(1'b0);
		host.seq(otpov_pkg::OTPOV_ENTRY, 3);
		fread(20'h00005, d2);
		stat(otpov_pkg::ST_OTP_LOCK, 1'b1);
		repeat (4) @(posedge clk);
		end_sim();
	end
endmodule : otp_overlay_region_control_tb

//--- otpov_host.sv
`timescale 1ns/100ps
// ==========================================================================
// Host controller model: one Avalon request at a time, held until accepted.
module otpov_host (
	input  wire logic        CORE_CLK,
	input  wire logic        AVS_WAITREQUEST,
	output logic      [3:0]  AVS_ADDRESS,
	output logic             AVS_READ,
	output logic             AVS_WRITE,
	output logic      [31:0] AVS_WRITEDATA,
	output logic      [3:0]  AVS_BYTEENABLE
);
	initial begin
		AVS_ADDRESS    = 4'h0;
		AVS_READ       = 1'b0;
		AVS_WRITE      = 1'b0;
		AVS_WRITEDATA  = 32'h00000000;
		AVS_BYTEENABLE = 4'hF;
	end

	// Write data is inverted once released, so a stale value cannot pass for a held one.
	task automatic xfer(input logic [3:0] a, input logic [31:0] d, input logic rd);
		@(posedge CORE_CLK);
		AVS_ADDRESS   <= a;
		AVS_WRITEDATA <= d;
		AVS_READ      <= rd;
		AVS_WRITE     <= !rd;
		do @(posedge CORE_CLK); while (AVS_WAITREQUEST !== 1'b0);
		AVS_READ      <= 1'b0;
		AVS_WRITE     <= 1'b0;
		AVS_WRITEDATA <= ~d;
	endtask : xfer

	// ==========================================================================
	// Entry takes three command cycles and exit takes four.
	task automatic seq(input otpov_pkg::otpov_cmd_type c, input int n);
		for (int i = 0; i < n; i++) begin
			xfer(otpov_pkg::REG_CMD, {28'h0000000, c}, 1'b0);
		end
	endtask : seq
endmodule : otpov_host

//--- otpov_pkg.sv
package otpov_pkg;

	// ==========================================================================
	// Geometry.
	localparam int          ADDR_W        = 20;
	localparam int          DATA_W        = 32;
	localparam int          OTP_WORDS     = 64;
	localparam int          OTP_AW        = 6;
	localparam logic [19:0] TOP_OTP_LO    = 20'h00000;
	localparam logic [19:0] TOP_OTP_HI    = 20'h0003F;
	localparam logic [19:0] BOT32_OTP_LO  = 20'hFFFC0;
	localparam logic [19:0] BOT32_OTP_HI  = 20'hFFFFF;
	localparam logic [19:0] BOT16_OTP_LO  = 20'h7FFC0;
	localparam logic [19:0] BOT16_OTP_HI  = 20'h7FFFF;
	localparam logic [19:0] TOP_INV_LO    = 20'h00040;
	localparam logic [19:0] TOP_INV_HI    = 20'h007FF;
	localparam logic [19:0] BOT_INV_LO    = 20'h0FF00;
	localparam logic [19:0] BOT_INV_HI    = 20'hFFF7F;
	localparam logic [5:0]  TOP_BOOT_SECT = 6'h00;
	localparam logic [5:0]  BOT_BOOT_SECT = 6'h2D;
	localparam int          NUM_SECT      = 46;
	localparam logic [31:0] INVALID_DATA  = 32'hFFFFFFFF;
	localparam logic [31:0] ERASED_WORD   = 32'hFFFFFFFF;

	// ==========================================================================
	// Register map.
	localparam logic [3:0]  REG_CMD       = 4'h0;
	localparam logic [3:0]  REG_ADDR      = 4'h1;
	localparam logic [3:0]  REG_WDATA     = 4'h2;
	localparam logic [3:0]  REG_RDATA     = 4'h3;
	localparam logic [3:0]  REG_STATUS    = 4'h4;
	localparam logic [3:0]  REG_CONFIG    = 4'h5;
	localparam logic [3:0]  REG_GUARD     = 4'h6;
	localparam logic [31:0] CONFIG_RESET  = 32'h00000000;
	localparam int          CFG_BOTTOM    = 0;
	localparam int          CFG_D16       = 1;
	localparam int          ST_OVERLAY    = 0;
	localparam int          ST_SUSP       = 1;
	localparam int          ST_BUSY       = 2;
	localparam int          ST_OTP_LOCK   = 3;
	localparam int          ST_OTP_PROG   = 4;
	localparam int          ST_IGNORED    = 5;
	localparam int          ST_BUSY_W     = 4;
	localparam logic [3:0]  BUSY_CYCLES   = 4'h8;

	// ==========================================================================
	// Commands.
	typedef enum logic [3:0] {
		OTPOV_NOP = 4'h0, OTPOV_READ = 4'h1, OTPOV_PROG = 4'h2, OTPOV_SECT_ERASE = 4'h3,
		OTPOV_CHIP_ERASE = 4'h4, OTPOV_SUSPEND = 4'h5, OTPOV_RESUME = 4'h6,
		OTPOV_BYPASS = 4'h7, OTPOV_CFI = 4'h8, OTPOV_ACCEL = 4'h9,
		OTPOV_ENTRY = 4'hA, OTPOV_EXIT = 4'hB, OTPOV_LOCK_OTP = 4'hC,
		OTPOV_GUARD_PROG = 4'hD, OTPOV_GUARD_VERIFY = 4'hE, OTPOV_PGUARD_OP = 4'hF
	} otpov_cmd_type;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} otpov_req_type;

endpackage : otpov_pkg

//--- otpov_seq.sv
`timescale 1ns/100ps
// ==========================================================================
// Unlock-cycle sequencer: counts entry and exit cycles.
module otpov_seq #(
	parameter int ENTRY_LEN = 3,
	parameter int EXIT_LEN  = 4
) (
	input  wire logic CORE_CLK,
	input  wire logic RST,
	input  wire logic cyc_entry,
	input  wire logic cyc_exit,
	output logic      entry_done,
	output logic      exit_done
);
	logic [2:0] ent_q;
	logic [2:0] ext_q;

	always_ff @(posedge CORE_CLK) begin
		if (RST || cyc_exit) begin
			ent_q <= 3'h0;
		end else if (cyc_entry) begin
			ent_q <= (ent_q == 3'(ENTRY_LEN - 1)) ? 3'h0 : ent_q + 3'h1;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST || cyc_entry) begin
			ext_q <= 3'h0;
		end else if (cyc_exit) begin
			ext_q <= (ext_q == 3'(EXIT_LEN - 1)) ? 3'h0 : ext_q + 3'h1;
		end
	end

	assign entry_done = cyc_entry && (ent_q == 3'(ENTRY_LEN - 1));
	assign exit_done  = cyc_exit && (ext_q == 3'(EXIT_LEN - 1));

endmodule : otpov_seq

//--- otpov_top.sv
// Local design decisions: the address map and the Avalon-MM slave port.
`timescale 1ns/100ps
module otpov_top #(
	parameter int ADDR_W = otpov_pkg::ADDR_W,
	parameter int DATA_W = otpov_pkg::DATA_W
) (
	input  wire logic        CORE_CLK,
	input  wire logic        RST,
	input  wire logic [3:0]  AVS_ADDRESS,
	input  wire logic        AVS_READ,
	input  wire logic        AVS_WRITE,
	input  wire logic [31:0] AVS_WRITEDATA,
	input  wire logic [3:0]  AVS_BYTEENABLE,
	output logic      [31:0] AVS_READDATA,
	output logic             AVS_WAITREQUEST,
	output logic             OVERLAY_ACTIVE
);
	// ==========================================================================
	// Storage: region words and a small main array model of sector tags.
	logic [DATA_W-1:0]          otp_mem [otpov_pkg::OTP_WORDS] = '{default: otpov_pkg::ERASED_WORD};
	logic [DATA_W-1:0]          arr_mem [otpov_pkg::OTP_WORDS];
	logic [otpov_pkg::NUM_SECT-1:0] sect_erased_q;
	logic [otpov_pkg::NUM_SECT-1:0] vguard_q;
	logic                       overlay_q;
	logic                       susp_q;
	logic                       otp_prog_q = 1'b0;
	logic                       otp_lock_q = 1'b0;
	logic                       ignored_q;
	logic [3:0]                 busy_q;
	logic [31:0]                config_q;
	otpov_pkg::otpov_req_type   req_q;
	logic [31:0]                rdata_q;
	logic                       ack_q;
	logic                       wr_fire;
	logic                       rd_fire;
	logic                       cmd_fire;
	otpov_pkg::otpov_cmd_type   cmd;
	logic                       entry_done;
	logic                       exit_done;
	logic                       bottom;
	logic                       d16;
	logic [5:0]                 boot_sect;
	logic [5:0]                 req_sect;
	logic                       in_region;
	logic [31:0]                read_value;

	function automatic logic in_rng(input logic [19:0] a, input logic [19:0] lo, input logic [19:0] hi);
		in_rng = (a >= lo) && (a <= hi);
	endfunction : in_rng

	// ==========================================================================
	// Bus handshake: one wait cycle, answer in the following cycle.
	assign wr_fire  = AVS_WRITE && ack_q;
	// Read data is loaded when the request is first seen, so it stands when waitrequest is sampled low.
	assign rd_fire  = AVS_READ && !ack_q;
	assign cmd_fire = wr_fire && (AVS_ADDRESS == otpov_pkg::REG_CMD);
	assign cmd      = otpov_pkg::otpov_cmd_type'(AVS_WRITEDATA[3:0]);

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= (AVS_READ || AVS_WRITE) && !ack_q;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			AVS_WAITREQUEST <= 1'b1;
		end else begin
			AVS_WAITREQUEST <= !((AVS_READ || AVS_WRITE) && !ack_q);
		end
	end

	// ==========================================================================
	// Address decode of the overlay window.
	assign bottom    = config_q[otpov_pkg::CFG_BOTTOM];
	assign d16       = config_q[otpov_pkg::CFG_D16];
	assign boot_sect = bottom ? otpov_pkg::BOT_BOOT_SECT : otpov_pkg::TOP_BOOT_SECT;
	assign req_sect  = req_q.addr[19:14];
	assign in_region = !bottom ? in_rng(req_q.addr, otpov_pkg::TOP_OTP_LO, otpov_pkg::TOP_OTP_HI) :
		(d16 ? in_rng(req_q.addr, otpov_pkg::BOT16_OTP_LO, otpov_pkg::BOT16_OTP_HI) :
		in_rng(req_q.addr, otpov_pkg::BOT32_OTP_LO, otpov_pkg::BOT32_OTP_HI));

	always_comb begin
		if (busy_q != 4'h0) begin
			read_value = 32'(busy_q);
		end else if (overlay_q && in_region) begin
			read_value = otp_mem[req_q.addr[5:0]];
		end else if (overlay_q) begin
			read_value = otpov_pkg::INVALID_DATA;
		end else if (sect_erased_q[req_sect]) begin
			read_value = otpov_pkg::ERASED_WORD;
		end else begin
			read_value = arr_mem[req_q.addr[5:0]];
		end
	end

	// ==========================================================================
	// Software registers.
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			req_q    <= '0;
			config_q <= otpov_pkg::CONFIG_RESET;
		end else if (wr_fire) begin
			if (AVS_ADDRESS == otpov_pkg::REG_ADDR) begin
				req_q.addr <= AVS_WRITEDATA[19:0];
			end
			if (AVS_ADDRESS == otpov_pkg::REG_WDATA) begin
				req_q.data <= AVS_WRITEDATA;
			end
			if (AVS_ADDRESS == otpov_pkg::REG_CONFIG && AVS_BYTEENABLE[0]) begin
				config_q <= {30'h0, AVS_WRITEDATA[1:0]};
			end
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			rdata_q <= 32'h0;
		end else if (cmd_fire && cmd == otpov_pkg::OTPOV_READ) begin
			rdata_q <= read_value;
		end else if (cmd_fire && cmd == otpov_pkg::OTPOV_GUARD_VERIFY) begin
			rdata_q <= (!overlay_q && req_sect == boot_sect) ? otpov_pkg::INVALID_DATA :
				{31'h0, vguard_q[req_sect]};
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			AVS_READDATA <= 32'h0;
		end else if (rd_fire) begin
			unique case (AVS_ADDRESS)
				otpov_pkg::REG_ADDR:   AVS_READDATA <= {12'h0, req_q.addr};
				otpov_pkg::REG_WDATA:  AVS_READDATA <= req_q.data;
				otpov_pkg::REG_RDATA:  AVS_READDATA <= rdata_q;
				otpov_pkg::REG_STATUS: AVS_READDATA <= {22'h0, busy_q, ignored_q, otp_prog_q, otp_lock_q,
					busy_q != 4'h0, susp_q, overlay_q};
				otpov_pkg::REG_CONFIG: AVS_READDATA <= config_q;
				otpov_pkg::REG_GUARD:  AVS_READDATA <= {18'h0, vguard_q[45:32]};
				default:               AVS_READDATA <= 32'h0;
			endcase
		end
	end

	// ==========================================================================
	// Entry and exit sequences.
	otpov_seq #(
		.ENTRY_LEN (3),
		.EXIT_LEN  (4)
	) u_seq (
		.CORE_CLK   (CORE_CLK),
		.RST        (RST),
		.cyc_entry  (cmd_fire && cmd == otpov_pkg::OTPOV_ENTRY),
		.cyc_exit   (cmd_fire && cmd == otpov_pkg::OTPOV_EXIT),
		.entry_done (entry_done),
		.exit_done  (exit_done)
	);

	// Power loss is modelled by reset; only the exit sequence clears it otherwise.
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			overlay_q <= 1'b0;
		end else if (exit_done) begin
			overlay_q <= 1'b0;
		end else if (entry_done) begin
			overlay_q <= 1'b1;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			OVERLAY_ACTIVE <= 1'b0;
		end else begin
			OVERLAY_ACTIVE <= overlay_q ? !exit_done : entry_done;
		end
	end

	// ==========================================================================
	// Suspend and resume; the host owns the resume after exit.
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			susp_q <= 1'b0;
		end else if (cmd_fire && !overlay_q) begin
			if (cmd == otpov_pkg::OTPOV_SUSPEND) begin
				susp_q <= 1'b1;
			end else if (cmd == otpov_pkg::OTPOV_RESUME) begin
				susp_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			ignored_q <= 1'b0;
		end else if (cmd_fire) begin
			ignored_q <= overlay_q && (cmd inside {otpov_pkg::OTPOV_BYPASS, otpov_pkg::OTPOV_CFI,
				otpov_pkg::OTPOV_ACCEL, otpov_pkg::OTPOV_SUSPEND, otpov_pkg::OTPOV_RESUME});
		end
	end

	// Status-returning guard and password operations.
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			busy_q <= 4'h0;
		end else if (cmd_fire && cmd == otpov_pkg::OTPOV_PGUARD_OP) begin
			busy_q <= otpov_pkg::BUSY_CYCLES;
		end else if (busy_q != 4'h0) begin
			busy_q <= busy_q - 4'h1;
		end
	end

	// ==========================================================================
	// Program, lock and erase.
	// The region and its flags are non-volatile: reset stands for power loss and leaves them alone.
	always_ff @(posedge CORE_CLK) begin
		if (cmd_fire && overlay_q && !otp_lock_q) begin
			if (cmd == otpov_pkg::OTPOV_PROG && in_region) begin
				otp_prog_q <= 1'b1;
			end
			if (cmd == otpov_pkg::OTPOV_LOCK_OTP) begin
				otp_lock_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (cmd_fire && cmd == otpov_pkg::OTPOV_PROG && overlay_q && in_region && !otp_lock_q && !otp_prog_q) begin
			otp_mem[req_q.addr[5:0]] <= otp_mem[req_q.addr[5:0]] & req_q.data;
		end
	end

	// Sector erase and chip erase never touch the region store above.
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			sect_erased_q <= '0;
		end else if (cmd_fire && cmd == otpov_pkg::OTPOV_SECT_ERASE && !(overlay_q && in_region)) begin
			sect_erased_q[req_sect] <= 1'b1;
		end else if (cmd_fire && cmd == otpov_pkg::OTPOV_CHIP_ERASE) begin
			sect_erased_q <= {otpov_pkg::NUM_SECT{1'b1}} & ~(46'h1 << boot_sect);
		end else if (cmd_fire && cmd == otpov_pkg::OTPOV_PROG && !overlay_q) begin
			sect_erased_q[req_sect] <= 1'b0;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (cmd_fire && cmd == otpov_pkg::OTPOV_PROG && !overlay_q) begin
			arr_mem[req_q.addr[5:0]] <= req_q.data;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			vguard_q <= '0;
		end else if (cmd_fire && cmd == otpov_pkg::OTPOV_GUARD_PROG && (overlay_q || req_sect != boot_sect)) begin
			vguard_q[req_sect] <= req_q.data[0];
		end
	end

	// ==========================================================================
	// Checks.
	property p_ovl_entry;
		@(posedge CORE_CLK) disable iff (RST) entry_done && !exit_done |=> overlay_q;
	endproperty
	a_ovl_entry: assert property (p_ovl_entry) else $error("Overlay not set after entry.");

	property p_ovl_hold;
		@(posedge CORE_CLK) disable iff (RST) overlay_q && !exit_done |=> overlay_q;
	endproperty
	a_ovl_hold: assert property (p_ovl_hold) else $error("Overlay dropped without exit.");

	property p_no_susp;
		@(posedge CORE_CLK) disable iff (RST)
			overlay_q && cmd_fire && cmd == otpov_pkg::OTPOV_SUSPEND |=> $stable(susp_q);
	endproperty
	a_no_susp: assert property (p_no_susp) else $error("Suspend taken under overlay.");

	property p_no_resume;
		@(posedge CORE_CLK) disable iff (RST)
			overlay_q && susp_q && cmd_fire && cmd == otpov_pkg::OTPOV_RESUME |=> susp_q;
	endproperty
	a_no_resume: assert property (p_no_resume) else $error("Resume taken under overlay.");

	property p_lock_sticky;
		@(posedge CORE_CLK) disable iff (RST) otp_lock_q |=> otp_lock_q;
	endproperty
	a_lock_sticky: assert property (p_lock_sticky) else $error("Region lock cleared.");

	property p_guard_boot;
		@(posedge CORE_CLK) disable iff (RST)
			!overlay_q && cmd_fire && cmd == otpov_pkg::OTPOV_GUARD_PROG && req_sect == boot_sect
			|=> $stable(vguard_q[boot_sect]);
	endproperty
	a_guard_boot: assert property (p_guard_boot) else $error("Boot guard bit changed.");

	property p_chip_spare;
		@(posedge CORE_CLK) disable iff (RST)
			cmd_fire && cmd == otpov_pkg::OTPOV_CHIP_ERASE |=> !sect_erased_q[boot_sect];
	endproperty
	a_chip_spare: assert property (p_chip_spare) else $error("Chip erase hit boot sector.");

	property p_busy_status;
		@(posedge CORE_CLK) disable iff (RST)
			cmd_fire && cmd == otpov_pkg::OTPOV_PGUARD_OP |=> (busy_q == otpov_pkg::BUSY_CYCLES) [*1] ##7 (busy_q == 4'h1);
	endproperty
	a_busy_status: assert property (p_busy_status) else $error("Status window length wrong.");

	property p_out_invalid;
		@(posedge CORE_CLK) disable iff (RST)
			overlay_q && !in_region && busy_q == 4'h0 |-> read_value == otpov_pkg::INVALID_DATA;
	endproperty
	a_out_invalid: assert property (p_out_invalid) else $error("Overlay read not invalid.");

	property p_ign_cmd;
		@(posedge CORE_CLK) disable iff (RST)
			overlay_q && cmd_fire && cmd inside {otpov_pkg::OTPOV_BYPASS, otpov_pkg::OTPOV_CFI, otpov_pkg::OTPOV_ACCEL}
			|=> ignored_q;
	endproperty
	a_ign_cmd: assert property (p_ign_cmd) else $error("Overlay command not ignored.");

	c_entry: cover property (@(posedge CORE_CLK) disable iff (RST) entry_done);
	c_ignored: cover property (@(posedge CORE_CLK) disable iff (RST) $rose(ignored_q));
	c_exit: cover property (@(posedge CORE_CLK) disable iff (RST) overlay_q && exit_done);
	c_lock: cover property (@(posedge CORE_CLK) disable iff (RST) $rose(otp_lock_q));

endmodule : otpov_top
